// ==== hdl/cfmc_pkg.sv ====
package cfmc_pkg;
  // register byte offsets
  localparam logic [7:0] CFMC_OFF_CFG    = 8'h00;
  localparam logic [7:0] CFMC_OFF_STATUS = 8'h04;
  localparam logic [7:0] CFMC_OFF_MASK   = 8'h08;
  localparam logic [7:0] CFMC_OFF_BITDIV = 8'h0C;
  localparam logic [7:0] CFMC_OFF_TOCNT  = 8'h10;
  // module_config_reg fields
  localparam int CFMC_B_FREEZE_EN  = 0;
  localparam int CFMC_B_HALT       = 1;
  localparam int CFMC_B_LPREQ      = 2;
  localparam int CFMC_B_MOD_DIS    = 3;
  localparam int CFMC_B_FLEX_EN    = 4;
  localparam int CFMC_B_SRST_REQ   = 5;
  localparam int CFMC_B_FREEZE_ACK = 8;
  localparam int CFMC_B_LP_ACK     = 9;
  localparam int CFMC_B_LOCK       = 10;
  // status / mask fields
  localparam int CFMC_S_FREEZE_ACK = 0;
  localparam int CFMC_S_LP_ACK     = 1;
  localparam int CFMC_S_RSTDONE = 2;
  localparam int CFMC_S_TMO     = 3;
  // reset values: freeze requested and enabled, as after a soft reset
  localparam logic [5:0] CFMC_CFG_RST  = 6'h03;
  localparam logic [3:0] CFMC_MASK_RST = 4'h0;
  localparam logic [15:0] CFMC_DIV_RST = 16'h0018;
  // timeouts in bit times at arbitration rate
  localparam logic [9:0] CFMC_TMO_FD   = 10'd730;
  localparam logic [9:0] CFMC_TMO_CLS  = 10'd180;
  // soft reset countdown load in core clocks; reset lasts one clock more
  localparam logic [3:0] CFMC_SRST_CYC = 4'h8;
  // cycles for mode entry to settle (bit times)
  localparam logic [9:0] CFMC_ENTRY_BITS = 10'd11;
  typedef enum logic [2:0] {
    CFMC_NORMAL, CFMC_FREEZE_WAIT, CFMC_FROZEN, CFMC_LP_WAIT, CFMC_LOWPWR,
    CFMC_SRST
  } cfmc_state_t;
endpackage

// ==== hdl/cfmc_bit_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
// bit-time tick generator from a software-set divider
module cfmc_bit_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // control
  input  wire logic [15:0] divide,
  output logic             bit_tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_tick;

  // count divide+1 clocks per bit; zero divider ticks every clock
  always_comb begin
    next_tick = (cnt >= divide);
    next_cnt  = next_tick ? 16'h0000 : cnt + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt      <= 16'h0000;
      bit_tick <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      bit_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/cfmc_mode_ctrl.sv ====
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cfmc_mode_ctrl (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // controller core side
  input  wire logic        can_idle,
  input  wire logic        ack_stall,
  output logic             bus_enable,
  output logic             core_reset,
  output logic             irq
);
  import cfmc_pkg::*;

  logic [5:0]  cfg;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic [15:0] bitdiv;
  logic [9:0]  tocnt;
  logic [3:0]  srcnt;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        idle_s1;
  logic        idle_s2;
  logic        stall_s1;
  logic        stall_s2;
  logic        bit_tick;
  cfmc_state_t state;

  logic [5:0]  next_cfg;
  logic [3:0]  next_status;
  logic [3:0]  next_mask;
  logic [15:0] next_bitdiv;
  logic [9:0]  next_tocnt;
  logic [3:0]  next_srcnt;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  logic        next_bus_enable;
  logic        next_core_reset;
  logic        next_irq;
  logic        lock;
  logic        next_lock;
  logic [3:0]  ev;
  cfmc_state_t next_state;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  cfmc_bit_timer u_bit (
    .core_clk (core_clk),
    .nrst     (nrst),
    .divide   (bitdiv),
    .bit_tick (bit_tick)
  );

  // core status lines come from another block; synchronise them
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      idle_s1  <= 1'b0;
      idle_s2  <= 1'b0;
      stall_s1 <= 1'b0;
      stall_s2 <= 1'b0;
    end else begin
      idle_s1  <= can_idle;
      idle_s2  <= idle_s1;
      stall_s1 <= ack_stall;
      stall_s2 <= stall_s1;
    end
  end

  // mode sequencer, register writes and interrupt events
  always_comb begin
    next_state   = state;
    next_cfg     = cfg;
    next_mask    = mask;
    next_bitdiv  = bitdiv;
    next_tocnt   = tocnt;
    next_srcnt   = srcnt;
    next_lock    = lock;
    ev           = 4'h0;
    next_wr_pend = hsel && hready && htrans[1] && hwrite;
    next_wr_addr = haddr;
    // data-phase write of the addressed register
    if (wr_pend) begin
      if (hit(wr_addr, CFMC_OFF_CFG)) begin
        next_cfg = hwdata[5:0];
        // soft reset only set by software, cleared by hardware
        next_cfg[CFMC_B_SRST_REQ] = cfg[CFMC_B_SRST_REQ] |
                                    hwdata[CFMC_B_SRST_REQ];
      end
      if (hit(wr_addr, CFMC_OFF_MASK))
        next_mask = hwdata[3:0];
      if (hit(wr_addr, CFMC_OFF_BITDIV))
        next_bitdiv = hwdata[15:0];
    end
    // soft reset beats any mode state
    if (cfg[CFMC_B_SRST_REQ] && state != CFMC_SRST) begin
      next_state = CFMC_SRST;
      next_srcnt = CFMC_SRST_CYC;
    end else begin
      case (state)
        CFMC_NORMAL: begin
          next_tocnt = 10'd0;
          // lowpower request ignored here: freeze must come first
          if (cfg[CFMC_B_FREEZE_EN] && cfg[CFMC_B_HALT])
            next_state = CFMC_FREEZE_WAIT;
        end
        CFMC_FREEZE_WAIT: begin
          // module_disable set blocks progress into freeze
          if (bit_tick && !cfg[CFMC_B_MOD_DIS] && idle_s2 && !stall_s2)
            next_tocnt = tocnt + 10'd1;
          if (tocnt >= CFMC_ENTRY_BITS) begin
            next_state = CFMC_FROZEN;
            ev[CFMC_S_FREEZE_ACK] = 1'b1;
          end else if (stall_s2 && bit_tick &&
                       tocnt == 10'd0) begin
            next_lock = 1'b1;
            ev[CFMC_S_TMO] = 1'b1;
          end
        end
        CFMC_FROZEN: begin
          next_tocnt = 10'd0;
          if (!cfg[CFMC_B_HALT] || !cfg[CFMC_B_FREEZE_EN])
            next_state = CFMC_NORMAL;
          else if (cfg[CFMC_B_LPREQ])
            next_state = CFMC_LP_WAIT;
        end
        CFMC_LP_WAIT: begin
          if (bit_tick && !stall_s2)
            next_tocnt = tocnt + 10'd1;
          if (stall_s2)
            next_lock = 1'b1;
          else if (tocnt >= CFMC_ENTRY_BITS) begin
            next_state = CFMC_LOWPWR;
            ev[CFMC_S_LP_ACK] = 1'b1;
          end
        end
        CFMC_LOWPWR: begin
          if (!cfg[CFMC_B_LPREQ])
            next_state = CFMC_FROZEN;
        end
        CFMC_SRST: begin
          if (srcnt != 4'h0) begin
            next_srcnt = srcnt - 4'h1;
          end else begin
            // config and mask defaults restored, controller lands in freeze
            next_cfg   = CFMC_CFG_RST;
            next_mask  = CFMC_MASK_RST;
            next_lock  = 1'b0;
            next_state = CFMC_FROZEN;
            ev[CFMC_S_RSTDONE] = 1'b1;
          end
        end
        default: next_state = CFMC_NORMAL;
      endcase
    end
    // while locked the wait never finishes
    if (lock && state != CFMC_SRST && !cfg[CFMC_B_SRST_REQ])
      next_state = state;
  end

  // status bits: hardware set wins over write-one clear
  always_comb begin
    next_status = status;
    if (wr_pend && hit(wr_addr, CFMC_OFF_STATUS))
      next_status = status & ~hwdata[3:0];
    next_status = next_status | ev;
    // timeout flag when tocnt reaches the timeout selected by the flex enable bit
    if (state == CFMC_FREEZE_WAIT && bit_tick &&
        tocnt == (cfg[CFMC_B_FLEX_EN] ? CFMC_TMO_FD : CFMC_TMO_CLS))
      next_status[CFMC_S_TMO] = 1'b1;
    next_irq        = |(next_status & next_mask);
    next_bus_enable = (next_state == CFMC_NORMAL);
    next_core_reset = (next_state == CFMC_SRST);
  end

  // read data for the next data phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (hit(haddr, CFMC_OFF_CFG)) begin
        next_hrdata[5:0] = cfg;
        next_hrdata[CFMC_B_FREEZE_ACK] = (state == CFMC_FROZEN) ||
                                         (state == CFMC_LOWPWR);
        next_hrdata[CFMC_B_LP_ACK] = (state == CFMC_LOWPWR);
        next_hrdata[CFMC_B_LOCK]   = lock;
      end
      if (hit(haddr, CFMC_OFF_STATUS))
        next_hrdata[3:0] = status;
      if (hit(haddr, CFMC_OFF_MASK))
        next_hrdata[3:0] = mask;
      if (hit(haddr, CFMC_OFF_BITDIV))
        next_hrdata[15:0] = bitdiv;
      if (hit(haddr, CFMC_OFF_TOCNT))
        next_hrdata[9:0] = tocnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state      <= CFMC_FROZEN;
      cfg        <= CFMC_CFG_RST;
      status     <= 4'h0;
      mask       <= CFMC_MASK_RST;
      bitdiv     <= CFMC_DIV_RST;
      tocnt      <= 10'd0;
      srcnt      <= 4'h0;
      lock       <= 1'b0;
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata     <= 32'h0000_0000;
      irq        <= 1'b0;
      bus_enable <= 1'b0;
      core_reset <= 1'b0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      state      <= next_state;
      cfg        <= next_cfg;
      status     <= next_status;
      mask       <= next_mask;
      bitdiv     <= next_bitdiv;
      tocnt      <= next_tocnt;
      srcnt      <= next_srcnt;
      lock       <= next_lock;
      wr_pend    <= next_wr_pend;
      wr_addr    <= next_wr_addr;
      hrdata     <= next_hrdata;
      irq        <= next_irq;
      bus_enable <= next_bus_enable;
      core_reset <= next_core_reset;
      // zero wait state, always OKAY
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/cfmc_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module cfmc_properties (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // core side
  input wire logic        bus_enable,
  input wire logic        core_reset,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // soft reset holds the core for at least 8 clocks
  sequence s_srst;
    core_reset [*8];
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus stalled");
  property p_rdidle;
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("stray data");
  property p_rel;
    $rose(nrst) |-> !bus_enable && !core_reset && !irq;
  endproperty
  a_rel: assert property (p_rel) else $error("bad reset state");
  property p_srst;
    $rose(core_reset) |-> s_srst ##[1:4] !core_reset;
  endproperty
  a_srst: assert property (p_srst) else $error("reset length");
  property p_srst_bus;
    core_reset |-> !bus_enable;
  endproperty
  a_srst_bus: assert property (p_srst_bus) else $error("bus on");
  property p_srst_frz;
    $fell(core_reset) |-> !bus_enable ##1 !bus_enable;
  endproperty
  a_srst_frz: assert property (p_srst_frz) else $error("not frozen");
  property p_irq_lvl;
    $rose(irq) |=> irq;
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("irq pulse");
  property p_en_rise;
    $rose(bus_enable) |-> !$past(core_reset);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("early run");
endmodule
bind cfmc_mode_ctrl cfmc_properties cfmc_properties_inst (.core_clk, .nrst,
  .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .bus_enable, .core_reset, .irq);
`default_nettype wire

// ==== verif/cfmc_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cfmc_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // from the controller
  input wire logic bus_enable,
  input wire logic core_reset,
  // scenario control
  input wire logic stall_cmd,
  input wire logic slow,
  // to the controller
  output logic     can_idle,
  output logic     ack_stall
);
  logic [3:0] busy;
  // a frame in flight ends some clocks after the bus is released
  always_ff @(posedge core_clk) begin
    if (!nrst || core_reset)
      busy <= 4'h0;
    else if (bus_enable)
      busy <= slow ? 4'hF : 4'h3;
    else if (busy != 4'h0)
      busy <= busy - 4'h1;
  end
  assign can_idle = (busy == 4'h0);
  // soft reset masks the stall of a hung core only while core_reset is high
  assign ack_stall = stall_cmd & !core_reset;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] CFG_A = 8'h00, ST_A = 8'h04, MSK_A = 8'h08;
  localparam logic [7:0] DIV_A = 8'h0C;
  logic core_clk = 0, nrst = 0, hsel = 0, hwrite = 0, stall = 0, slow = 0;
  logic [1:0] htrans = 0;
  logic [7:0] haddr = 0;
  logic [31:0] hwdata = 0, q, d;
  wire logic [31:0] hrdata;
  wire logic hrdy, hresp, can_idle, ack_stall, bus_enable, core_reset, irq;
  int miscompares = 0, total_checks = 0, cfg_m, f;
  initial forever #20 core_clk = ~core_clk;
  cfmc_mode_ctrl cfmc_mode_ctrl_inst (.core_clk, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hrdy), .hrdata,
    .hreadyout(hrdy), .hresp, .can_idle, .ack_stall, .bus_enable,
    .core_reset, .irq);
  cfmc_core_model cfmc_core_model_inst (.core_clk, .nrst, .bus_enable,
    .core_reset, .stall_cmd(stall), .slow, .can_idle, .ack_stall);
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // single word transfer; the shadow copy tracks config writes
  task bus(input logic w, input logic [7:0] a, input logic [31:0] dd);
    @(posedge core_clk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge core_clk); while (hrdy !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= dd;
    do @(posedge core_clk); while (hrdy !== 1'b1);
    q = hrdata;
    if (w && a == CFG_A) cfg_m = dd & 32'h1F;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(0, a, 32'h0);
    chk(n, e, q);
  endtask
  // bounded poll, as software does while waiting for an acknowledge
  task poll(input int b, input logic v, input string n);
    for (int i = 0; i < 300; i++) begin
      bus(0, CFG_A, 32'h0);
      if (q[b] === v) break;
    end
    chk(n, {31'h0, v}, {31'h0, q[b]});
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, well beyond the longest poll sequence
  initial begin
    #(40 * 40000);
    miscompares++;
    summarize;
  end
  initial begin
    void'($urandom(55));
    repeat (2) @(posedge core_clk);
    nrst <= 1;
    cfg_m = 32'h3;
    rd(CFG_A, 32'h103, "cfg_rst");
    rd(DIV_A, 32'h18, "div_rst");
    rd(MSK_A, 32'h0, "mask_rst");
    rd(8'h40, 32'h0, "unmapped");
    d = $urandom % 4;
    bus(1, DIV_A, d);
    rd(DIV_A, d, "div");
    bus(1, DIV_A, 32'h0);
    bus(1, CFG_A, 32'h0);
    rd(CFG_A, cfg_m, "cfg_run");
    chk("run_bus", 1, bus_enable);
    bus(1, CFG_A, 32'h4);
    repeat (40) @(posedge core_clk);
    rd(CFG_A, cfg_m, "lp_direct");
    chk("lp_bus", 1, bus_enable);
    // freeze entry with a prompt and a slow core
    for (f = 0; f < 2; f++) begin
      slow <= f[0];
      bus(1, CFG_A, 32'h0);
      bus(1, CFG_A, 32'h3);
      poll(8, 1, "frz_ack");
      chk("frz_bus", 0, bus_enable);
    end
    bus(1, CFG_A, 32'h0);
    bus(1, CFG_A, 32'hB);
    repeat (60) @(posedge core_clk);
    rd(CFG_A, cfg_m, "disabled");
    bus(1, CFG_A, 32'h3);
    poll(8, 1, "module_disable_clr");
    bus(1, CFG_A, 32'h7);
    poll(9, 1, "lp_ack");
    bus(1, CFG_A, 32'h3);
    poll(9, 0, "lp_exit");
    // interrupt raised, masked and cleared
    bus(1, MSK_A, 32'h1);
    @(posedge core_clk);
    chk("irq_on", 1, irq);
    bus(1, MSK_A, 32'h0);
    @(posedge core_clk);
    chk("irq_mask", 0, irq);
    bus(1, MSK_A, 32'h1);
    bus(1, ST_A, 32'hF);
    @(posedge core_clk);
    chk("irq_clr", 0, irq);
    // hung acknowledge, recovered by soft reset, with the flex enable bit clear and set
    for (f = 0; f < 2; f++) begin
      bus(1, CFG_A, 32'h0);
      stall <= 1;
      bus(1, CFG_A, 32'h3 | (f << 4));
      repeat (f ? 730 : 180) @(posedge core_clk);
      rd(CFG_A, cfg_m | 32'h400, "lock");
      stall <= 0;
      bus(1, CFG_A, cfg_m | 32'h20);
      poll(5, 0, "srst_done");
      cfg_m = 32'h3;
      rd(CFG_A, 32'h103, "srst_frz");
      rd(MSK_A, 32'h0, "srst_mask");
      bus(0, ST_A, 32'h0);
      chk("rst_flag", 1, q[2]);
      bus(1, MSK_A, 32'h1);
    end
    summarize;
  end
endmodule
`default_nettype wire
